/* inc/msq_pkg.sv */
package msq_pkg;

    // =========================================================
    // Time base
    // =========================================================
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned MS_PER_S   = 1000;
    localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S;
    localparam int unsigned PRE_W      = 17;
    localparam int unsigned MS_W       = 10;

    localparam logic [MS_W-1:0] TURN_ON_MS    = MS_W'(500);
    localparam logic [MS_W-1:0] TURN_OFF_MS   = MS_W'(650);
    localparam logic [MS_W-1:0] RESET_MIN_MS  = MS_W'(150);
    localparam logic [MS_W-1:0] SHUTDOWN_MS   = MS_W'(2);
    localparam logic [MS_W-1:0] RESTART_MS    = MS_W'(2);

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FUNC   = 8'h04;
    localparam logic [7:0] ADDR_EVENT  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    localparam int unsigned CTRL_SLEEP_BIT  = 0;
    localparam int unsigned CTRL_APLANE_BIT = 1;
    localparam int unsigned CTRL_HPOL_BIT   = 2;
    localparam int unsigned CTRL_LINK_LSB   = 4;
    localparam int unsigned EVT_PDOWN_BIT   = 0;
    localparam int unsigned EVT_URC_BIT     = 1;
    localparam int unsigned ST_SLEEP_BIT    = 2;
    localparam int unsigned ST_RADIO_BIT    = 3;
    localparam int unsigned ST_SIM_BIT      = 4;
    localparam int unsigned ST_DL_BIT       = 5;
    localparam int unsigned ST_HOST_BIT     = 6;
    localparam int unsigned ST_AIR_BIT      = 7;

    localparam logic [2:0] FUN_MIN  = 3'h0;
    localparam logic [2:0] FUN_FULL = 3'h1;
    localparam logic [2:0] FUN_AIR  = 3'h4;

    localparam logic [7:0] SYNC_RST = 8'h0F;

    typedef enum logic [1:0] {
        PS_OFF  = 2'b00,
        PS_ON   = 2'b01,
        PS_SHDN = 2'b11,
        PS_RST  = 2'b10
    } msq_pwr_e;

    typedef enum logic [1:0] {
        LINK_UART   = 2'h0,
        LINK_REMOTE = 2'h1,
        LINK_SUSP   = 2'h2,
        LINK_NOSUSP = 2'h3
    } msq_link_e;

    typedef struct packed {
        msq_link_e link;
        logic      host_pol;
        logic      aplane_en;
        logic      sleep_en;
    } msq_cfg_s;

    localparam msq_cfg_s CFG_RST = '{LINK_UART, 1'b1, 1'b0, 1'b0};

    typedef struct packed {
        logic fdl;
        logic bus_pwr;
        logic suspended;
        logic host_rdy;
        logic wdis_n;
        logic dtr;
        logic rst_n;
        logic key_n;
    } msq_pins_s;

endpackage

/* logic/msq_sequencer.sv */
`timescale 1ns/100ps

// =========================================================
// Millisecond pulse timer
// =========================================================
// Counts whole milliseconds while run is high, saturates, and
// clears when run falls. The prescaler restarts with run, so a
// reading of N means at least N full milliseconds have passed.
module msq_ms_timer
    import msq_pkg::*;
#(
    parameter int unsigned MS_TICKS = MS_CYCLES
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            clk_en,
    input  wire logic            run,
    output      logic [MS_W-1:0] ms
);
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic [MS_W-1:0]  next_ms;

    always_comb begin
        next_pre = pre;
        next_ms  = ms;
        if (!run) begin
            next_pre = '0;
            next_ms  = '0;
        end else if (pre == PRE_W'(MS_TICKS - 1)) begin
            next_pre = '0;
            if (ms != '1) begin
                next_ms = ms + MS_W'(1);
            end
        end else begin
            next_pre = pre + PRE_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= '0;
            ms  <= '0;
        end else if (clk_en) begin
            pre <= next_pre;
            ms  <= next_ms;
        end
    end
endmodule

// =========================================================
// Power and mode sequencer
// =========================================================
module msq_sequencer
    import msq_pkg::*;
#(
    parameter int unsigned MS_TICKS = MS_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    input  wire logic        power_key_n,
    input  wire logic        reset_in_n,
    input  wire logic        terminal_ready_in,
    input  wire logic        radio_disable_n,
    input  wire logic        host_processor_ready,
    input  wire logic        usb_suspended,
    input  wire logic        usb_bus_power_sense,
    input  wire logic        forced_download_in,
    input  wire logic        usb_rx_activity,
    input  wire logic        radio_cmd_req,
    output      logic        status_out,
    output      logic        ring_indicate_out,
    output      logic        usb_remote_wakeup,
    output      logic        radio_enable,
    output      logic        sim_enable,
    output      logic        gnss_enable,
    output      logic        sleep_active,
    output      logic        download_mode,
    output      logic        radio_cmd_accept,
    output      logic        radio_cmd_reject
);
    // =========================================================
    // Pin synchronisers and pulse timers
    // =========================================================
    msq_pins_s        sync_a;
    msq_pins_s        pin;
    logic [MS_W-1:0]  key_ms;
    logic [MS_W-1:0]  rst_ms;
    logic [MS_W-1:0]  st_ms;
    msq_pwr_e         pwr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= SYNC_RST;
            pin    <= SYNC_RST;
        end else if (clk_en) begin
            sync_a <= {forced_download_in, usb_bus_power_sense,
                       usb_suspended, host_processor_ready,
                       radio_disable_n, terminal_ready_in,
                       reset_in_n, power_key_n};
            pin    <= sync_a;
        end
    end

    msq_ms_timer #(.MS_TICKS(MS_TICKS)) u_key_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (!pin.key_n),
        .ms      (key_ms)
    );
    msq_ms_timer #(.MS_TICKS(MS_TICKS)) u_rst_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (!pin.rst_n),
        .ms      (rst_ms)
    );
    msq_ms_timer #(.MS_TICKS(MS_TICKS)) u_state_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (pwr == PS_SHDN || pwr == PS_RST),
        .ms      (st_ms)
    );

    // =========================================================
    // APB slave
    // =========================================================
    msq_cfg_s    cfg;
    logic [2:0]  func;
    logic        urc_pending;
    logic        host_awake;
    logic        airplane;
    logic        acc;
    logic        wr_ok;
    logic        pdown_req;
    logic        urc_set;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;
    msq_cfg_s    next_cfg;
    logic [2:0]  next_func;
    logic        func_ok;

    assign acc     = psel && penable && !pready;
    assign wr_ok   = psel && penable && pready && pwrite && !pslverr;
    assign func_ok = pwdata[2:0] == FUN_MIN || pwdata[2:0] == FUN_FULL ||
                     pwdata[2:0] == FUN_AIR;
    assign pdown_req = wr_ok && paddr == ADDR_EVENT &&
                       pwdata[EVT_PDOWN_BIT];
    assign urc_set   = wr_ok && paddr == ADDR_EVENT &&
                       pwdata[EVT_URC_BIT];

    always_comb begin
        next_pready  = acc;
        next_pslverr = 1'b0;
        next_prdata  = '0;
        next_cfg     = cfg;
        next_func    = func;
        if (acc) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    next_prdata[CTRL_SLEEP_BIT]  = cfg.sleep_en;
                    next_prdata[CTRL_APLANE_BIT] = cfg.aplane_en;
                    next_prdata[CTRL_HPOL_BIT]   = cfg.host_pol;
                    next_prdata[CTRL_LINK_LSB+:2] = cfg.link;
                end
                ADDR_FUNC: begin
                    next_prdata[2:0] = func;
                    next_pslverr     = pwrite && !func_ok;
                end
                ADDR_EVENT: begin
                    next_prdata[EVT_URC_BIT] = urc_pending;
                end
                ADDR_STATUS: begin
                    next_prdata[1:0]          = pwr;
                    next_prdata[ST_SLEEP_BIT] = sleep_active;
                    next_prdata[ST_RADIO_BIT] = radio_enable;
                    next_prdata[ST_SIM_BIT]   = sim_enable;
                    next_prdata[ST_DL_BIT]    = download_mode;
                    next_prdata[ST_HOST_BIT]  = host_awake;
                    next_prdata[ST_AIR_BIT]   = airplane;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
        if (wr_ok && paddr == ADDR_CTRL) begin
            next_cfg.sleep_en  = pwdata[CTRL_SLEEP_BIT];
            next_cfg.aplane_en = pwdata[CTRL_APLANE_BIT];
            next_cfg.host_pol  = pwdata[CTRL_HPOL_BIT];
            next_cfg.link      = msq_link_e'(pwdata[CTRL_LINK_LSB+:2]);
        end
        if (wr_ok && paddr == ADDR_FUNC) begin
            next_func = pwdata[2:0];
        end
        // Leaving the running state drops the level back to default.
        if (pwr != PS_ON) begin
            next_func = FUN_FULL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
            cfg     <= CFG_RST;
            func    <= FUN_FULL;
        end else if (clk_en) begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
            cfg     <= next_cfg;
            func    <= next_func;
        end
    end

    // =========================================================
    // Power sequencing
    // =========================================================
    msq_pwr_e next_pwr;
    logic     off_armed;
    logic     next_armed;
    logic     next_dl;
    logic     key_off_go;
    logic     rst_go;

    // The key that turned the device on is still held; only a key
    // seen high while running may arm a turn-off.
    assign key_off_go = pin.key_n && off_armed && key_ms >= TURN_OFF_MS;
    assign rst_go     = pin.rst_n && rst_ms >= RESET_MIN_MS;

    always_comb begin
        next_pwr   = pwr;
        next_dl    = download_mode;
        next_armed = (pwr == PS_ON) && (off_armed || pin.key_n);
        unique case (pwr)
            PS_OFF: begin
                if (!pin.key_n && key_ms >= TURN_ON_MS) begin
                    next_pwr   = PS_ON;
                    next_armed = 1'b0;
                    next_dl    = pin.fdl;
                end
            end
            PS_ON: begin
                if (pdown_req || key_off_go) begin
                    next_pwr = PS_SHDN;
                end else if (rst_go) begin
                    next_pwr = PS_RST;
                end
            end
            PS_SHDN: begin
                if (st_ms >= SHUTDOWN_MS) begin
                    next_pwr = PS_OFF;
                    next_dl  = 1'b0;
                end
            end
            PS_RST: begin
                if (st_ms >= RESTART_MS) begin
                    next_pwr = PS_ON;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr           <= PS_OFF;
            off_armed     <= 1'b0;
            download_mode <= 1'b0;
            status_out    <= 1'b0;
        end else if (clk_en) begin
            pwr           <= next_pwr;
            off_armed     <= next_armed;
            download_mode <= next_dl;
            status_out    <= next_pwr == PS_ON;
        end
    end

    // =========================================================
    // Modes, sleep and wake signalling
    // =========================================================
    logic on;
    logic usb_stay;
    logic sleep_ok;
    logic next_stay;
    logic next_urc;

    assign on         = pwr == PS_ON;
    assign host_awake = pin.host_rdy == cfg.host_pol;
    assign airplane   = func == FUN_AIR ||
                        (cfg.aplane_en && !pin.wdis_n);

    always_comb begin
        next_stay = usb_stay;
        if (!pin.suspended) begin
            next_stay = 1'b0;
        end
        if (usb_rx_activity) begin
            next_stay = 1'b1;
        end
        sleep_ok = on && cfg.sleep_en && pin.dtr;
        unique case (cfg.link)
            LINK_UART:   sleep_ok = sleep_ok;
            LINK_REMOTE,
            LINK_SUSP:   sleep_ok = sleep_ok && pin.suspended &&
                                    !usb_stay;
            LINK_NOSUSP: sleep_ok = sleep_ok && !pin.bus_pwr;
        endcase
        // A new result wins over delivery in the same cycle.
        next_urc = urc_set || (urc_pending && on && !host_awake);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_stay          <= 1'b0;
            urc_pending       <= 1'b0;
            sleep_active      <= 1'b0;
            ring_indicate_out <= 1'b0;
            usb_remote_wakeup <= 1'b0;
            radio_enable      <= 1'b0;
            sim_enable        <= 1'b0;
            gnss_enable       <= 1'b0;
            radio_cmd_accept  <= 1'b0;
            radio_cmd_reject  <= 1'b0;
        end else if (clk_en) begin
            usb_stay          <= next_stay;
            urc_pending       <= next_urc;
            sleep_active      <= sleep_ok;
            ring_indicate_out <= on && urc_pending &&
                                 cfg.link != LINK_REMOTE;
            usb_remote_wakeup <= on && urc_pending && pin.suspended &&
                                 cfg.link == LINK_REMOTE;
            radio_enable      <= on && func == FUN_FULL && !airplane;
            sim_enable        <= on && func != FUN_MIN;
            gnss_enable       <= on;
            radio_cmd_accept  <= radio_cmd_req && radio_enable;
            radio_cmd_reject  <= radio_cmd_req && !radio_enable;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TURN_ON: assert property (
        (clk_en && pwr == PS_OFF && !pin.key_n && key_ms >= TURN_ON_MS)
        |=> status_out && pwr == PS_ON)
        else $error("long key press did not turn the device on");
    AST_SHORT_KEY: assert property (
        (clk_en && pwr == PS_OFF && key_ms < TURN_ON_MS) |=> !status_out)
        else $error("short key press turned the device on");
    AST_TURN_OFF: assert property (
        (clk_en && on && key_off_go) |=> pwr == PS_SHDN ##1 !status_out)
        else $error("key turn-off did not start shutdown");
    AST_PDOWN: assert property (
        (clk_en && on && pdown_req) |=> pwr == PS_SHDN)
        else $error("power-down command ignored");
    AST_RESET: assert property (
        (clk_en && on && !pdown_req && !key_off_go && rst_go)
        |=> pwr == PS_RST)
        else $error("valid reset pulse did not restart");
    AST_AIRPLANE: assert property (
        (clk_en && cfg.aplane_en && !pin.wdis_n) |=> !radio_enable)
        else $error("radio left on with radio-disable low");
    AST_REJECT: assert property (
        (clk_en && radio_cmd_req && !radio_enable)
        |=> radio_cmd_reject && !radio_cmd_accept)
        else $error("radio command not rejected");
    AST_GNSS: assert property (
        (clk_en && on && $changed(func)) |=> gnss_enable)
        else $error("positioning dropped on level change");
    AST_DTR_WAKE: assert property (
        (clk_en && !pin.dtr) |=> !sleep_active)
        else $error("terminal-ready low did not wake");
    AST_RING: assert property (
        (clk_en && on && urc_pending && cfg.link == LINK_UART)
        |=> ring_indicate_out)
        else $error("ring indicate missing for pending result");
    AST_FORCED_DL: assert property (
        (clk_en && pwr == PS_OFF && next_pwr == PS_ON && pin.fdl)
        |=> download_mode)
        else $error("forced download not entered");

    COV_TURN_ON: cover property ($rose(status_out));
    COV_SLEEP:   cover property ($rose(sleep_active));
    COV_REMOTE:  cover property ($rose(usb_remote_wakeup));
    COV_RESTART: cover property (pwr == PS_RST ##1 pwr == PS_ON);
endmodule

/* test/msq_host_model.sv */
`timescale 1ns/100ps

// ==========
// Host side of the power and reset pins
// ==========
// The host drives both lines push-pull: low, or driven high when released.
// The supply is never cut in this model, so a shutdown is always orderly.
module msq_host_model #(
    parameter int unsigned MS_TICKS = 4
) (
    input  wire logic pclk,
    input  wire logic status_out,
    output      logic power_key_n,
    output      logic reset_in_n
);
    bit settled;

    initial begin
        power_key_n = 1'b1;
        reset_in_n  = 1'b1;
        settled     = 1'b0;
    end

    task automatic press_key(input int ms, input bit hold_on,
                             output int cyc);
        if (!settled) repeat (30 * MS_TICKS) @(posedge pclk);
        settled = 1'b1;
        @(posedge pclk);
        power_key_n <= 1'b0;
        cyc = 0;
        while (cyc < 6000 && (cyc < ms * MS_TICKS ||
               (hold_on && status_out !== 1'b1))) begin
            @(posedge pclk);
            cyc++;
        end
        power_key_n <= 1'b1;
    endtask

    // Only used once the key path has been exercised.
    task automatic pulse_reset(input int ms);
        @(posedge pclk);
        reset_in_n <= 1'b0;
        repeat (ms * MS_TICKS) @(posedge pclk);
        reset_in_n <= 1'b1;
    endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps

// ==========
// Bench for the power and mode sequencer
// ==========
module tb_top;
    import msq_pkg::*;
    localparam int unsigned MS = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, m_ctrl;
    logic        power_key_n, reset_in_n, dtr, wdis_n, hrdy, susp, vbus;
    logic        fdl, rxact, rcmd, err, status_out, ring, rwake, radio;
    logic        sim, gnss, slp, dl, acc, rej, ce;
    int          err_count, comparisons, seed, cyc, ticks, m_func, v;
    int          lv[3] = '{0, 4, 1};
    bit          m_on, m_pend, woken;

    msq_sequencer #(.MS_TICKS(MS)) u_msq_sequencer (
        .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_key_n(power_key_n),
        .reset_in_n(reset_in_n), .terminal_ready_in(dtr),
        .radio_disable_n(wdis_n), .host_processor_ready(hrdy),
        .usb_suspended(susp), .usb_bus_power_sense(vbus),
        .forced_download_in(fdl), .usb_rx_activity(rxact),
        .radio_cmd_req(rcmd), .status_out(status_out),
        .ring_indicate_out(ring), .usb_remote_wakeup(rwake),
        .radio_enable(radio), .sim_enable(sim), .gnss_enable(gnss),
        .sleep_active(slp), .download_mode(dl),
        .radio_cmd_accept(acc), .radio_cmd_reject(rej));
    msq_host_model #(.MS_TICKS(MS)) u_msq_host_model (
        .pclk(pclk), .status_out(status_out),
        .power_key_n(power_key_n), .reset_in_n(reset_in_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        ticks++;
        if (ticks == 40000) begin
            err_count++;
            $display("unexpected at %0t: run timed out", $time);
            final_report;
        end
    end

    task automatic final_report;
        $display("checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_pin(input logic got, input logic exp, input string s);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s is %b", $time, s, got);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: read %h not %h", $time, got, exp);
        end
    endtask

    // The master never assumes a latency; only the run timeout ends a hang.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ok;
        ok = d inside {32'h0, 32'h1, 32'h4};
        apb(1'b1, a, d);
        if (a == ADDR_CTRL) m_ctrl = d & 32'h37;
        if (a == ADDR_FUNC && ok) m_func = d;
        if (a == ADDR_EVENT && d[1]) m_pend = 1'b1;
        if (a == ADDR_EVENT && d[0]) m_on = 1'b0;
        chk_pin(err, a == ADDR_FUNC && !ok, "error");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, e);
    endtask

    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask

    function automatic logic exp_radio;
        return m_on && m_func == 1 && !(m_ctrl[1] && !wdis_n);
    endfunction

    task automatic chk_outs;
        logic [1:0] lk;
        logic       s;
        lk = m_ctrl[5:4];
        if (!susp) woken = 1'b0;
        if (!m_on || hrdy === m_ctrl[2]) m_pend = 1'b0;
        s = lk == 0 || (lk == 3 && !vbus) || (lk inside {1, 2} && susp
            && !woken);
        chk_pin(status_out, m_on, "status");
        chk_pin(radio, exp_radio(), "radio");
        chk_pin(sim, m_on && m_func != 0, "sim");
        chk_pin(gnss, m_on, "gnss");
        chk_pin(slp, m_on && m_ctrl[0] && dtr && s, "sleep");
        chk_pin(ring, m_on && m_pend && lk != 1, "ring");
        chk_pin(rwake, m_on && m_pend && susp && lk == 1, "wakeup");
    endtask

    task automatic radio_cmd;
        @(posedge pclk);
        rcmd <= 1'b1;
        @(posedge pclk);
        rcmd <= 1'b0;
        @(posedge pclk);
        chk_pin(acc, exp_radio(), "accept");
        chk_pin(rej, !exp_radio(), "reject");
    endtask

    initial begin
        seed = 42;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {dtr, wdis_n, vbus, hrdy, susp, fdl, rxact, rcmd} = 8'hE0;
        {presetn, m_on, m_pend, woken} = '0;
        m_ctrl = 32'h4;
        m_func = 1;
        ce = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h4);
        rd_chk(ADDR_FUNC, 32'h1);
        rd_chk(ADDR_STATUS, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk_pin(err, 1'b1, "unmapped");
        $display("test reset values done");
        v = 10 + ($random(seed) & 255);
        u_msq_host_model.press_key(v, 1'b0, cyc);
        settle;
        chk_outs;
        fdl <= 1'b1;
        u_msq_host_model.press_key(500, 1'b1, cyc);
        fdl <= 1'b0;
        m_on = 1'b1;
        chk_pin(cyc >= 500 * MS && cyc <= 500 * MS + 10, 1'b1, "on");
        settle;
        chk_pin(dl, 1'b1, "download");
        rd_chk(ADDR_STATUS, 32'h39);
        $display("test turn-on done");
        foreach (lv[i]) begin
            wr(ADDR_FUNC, 32'(lv[i]));
            settle;
            chk_outs;
            radio_cmd;
        end
        do v = $random(seed) & 7; while (v inside {0, 1, 4});
        wr(ADDR_FUNC, 32'(v));
        rd_chk(ADDR_FUNC, 32'h1);
        wdis_n <= 1'b0;
        settle;
        chk_outs;
        wr(ADDR_CTRL, 32'h6);
        settle;
        chk_outs;
        rd_chk(ADDR_STATUS, 32'hB1);
        radio_cmd;
        wdis_n <= 1'b1;
        $display("test levels done");
        wr(ADDR_CTRL, 32'h5);
        settle;
        chk_outs;
        dtr <= 1'b0;
        settle;
        chk_outs;
        dtr <= 1'b1;
        susp <= 1'b1;
        wr(ADDR_CTRL, 32'h25);
        settle;
        chk_outs;
        rxact <= 1'b1;
        @(posedge pclk);
        rxact <= 1'b0;
        woken = 1'b1;
        settle;
        chk_outs;
        susp <= 1'b0;
        vbus <= 1'b0;
        wr(ADDR_CTRL, 32'h35);
        settle;
        chk_outs;
        vbus <= 1'b1;
        settle;
        chk_outs;
        for (int k = 0; k < 4; k++) begin
            susp <= k inside {1, 2};
            wr(ADDR_CTRL, {26'h0, 2'(k), 4'h4});
            wr(ADDR_EVENT, 32'h2);
            settle;
            chk_outs;
            rd_chk(ADDR_EVENT, {30'h0, m_pend, 1'b0});
        end
        wr(ADDR_CTRL, 32'h0);
        susp <= 1'b0;
        settle;
        chk_outs;
        $display("test sleep and wakeup done");
        wr(ADDR_FUNC, 32'h0);
        u_msq_host_model.pulse_reset(100);
        settle;
        chk_outs;
        u_msq_host_model.pulse_reset(151);
        repeat (5) @(posedge pclk);
        chk_pin(status_out, 1'b0, "restart");
        m_func = 1;
        repeat (2 * MS + 8) @(posedge pclk);
        chk_outs;
        $display("test reset pulse done");
        u_msq_host_model.press_key(300, 1'b0, cyc);
        settle;
        chk_outs;
        u_msq_host_model.press_key(651, 1'b0, cyc);
        m_on = 1'b0;
        repeat (2 * MS + 8) @(posedge pclk);
        chk_outs;
        u_msq_host_model.press_key(500, 1'b1, cyc);
        m_on = 1'b1;
        settle;
        chk_outs;
        // With the enable low the timers must not advance, so a long
        // press is ignored and the device keeps running.
        ce <= 1'b0;
        u_msq_host_model.press_key(651, 1'b0, cyc);
        ce <= 1'b1;
        settle;
        chk_outs;
        wr(ADDR_EVENT, 32'h1);
        repeat (2 * MS + 8) @(posedge pclk);
        chk_outs;
        repeat (600 * MS) @(posedge pclk);
        chk_outs;
        $display("test turn-off done");
        final_report;
    end
endmodule
